// >>> rtl/core_exec_defines.svh
// Constants for the instruction execution unit: register offsets, field positions, reset values.
// Assumes inclusion by bare name from files under rtl/.
`ifndef CORE_EXEC_DEFINES_SVH
`define CORE_EXEC_DEFINES_SVH

// Byte offsets on the register bus, one aligned word each
`define UPPER_LATCH_OFS 5'h00
`define STATUS_OFS 5'h04
`define ACCUM_OFS 5'h08
`define PC_OFS 5'h0C
`define STACK_TOP_OFS 5'h10
`define WATCHDOG_OFS 5'h14
`define FILE_SEL_OFS 5'h18
`define FILE_DATA_OFS 5'h1C

// Status word layout
`define ZERO_FLAG_BIT 2
`define SLEEP_FLAG_BIT 3
`define EXPIRY_FLAG_BIT 4

// Upper latch bits that feed program counter bits 12:11 on a call
`define PAGE_HI_BIT 4
`define PAGE_LO_BIT 3

// Reset values
`define UPPER_LATCH_RST 5'h00
`define PC_RST 13'h0000
`define ACCUM_RST 8'h00
`define ZERO_FLAG_RST 1'b0
`define SLEEP_FLAG_RST 1'b1
`define EXPIRY_FLAG_RST 1'b1
`define FILE_SEL_RST 7'h00
`define WATCHDOG_CLEAR 8'h00
`define READ_ZERO 32'h0000_0000

`endif

// >>> rtl/core_exec_pkg.sv
// Types shared by the instruction execution unit.
// Assumes nothing beyond a SystemVerilog compiler.
package core_exec_pkg;

  typedef enum logic [2:0] {
    OP_NOP,
    OP_BIT_TEST_SKIP_IF_ONE,
    OP_WATCHDOG_KICK,
    OP_CALL,
    OP_INVERT_REGISTER,
    OP_ZERO_REGISTER,
    OP_DECREMENT_REGISTER,
    OP_ZERO_ACCUMULATOR
  } opcode_t;

  typedef enum logic {
    EXEC_CYCLE,
    CALL_SECOND_CYCLE
  } exec_state_t;

endpackage

// >>> rtl/core_instruction_semantics.sv
// Execution unit for a subset of an 8-bit core: skip test, watchdog kick, call, register ops.
// Assumes a fetch stage that presents one instruction with valid/ready, and an Avalon-MM master.
`timescale 1ns/1ps
`include "core_exec_defines.svh"

// How it works
// [RL1] Set tested bit discards the next instruction
// [RL2] Watchdog kick clears counter and prescaler
// [RL3] Watchdog kick sets expiry and sleep flags
// [RL4] Call pushes following address onto stack
// [RL5] Call loads eleven-bit target into PC[10:0]
// [RL6] Call takes PC[12:11] from latch bits 4:3
// [RL7] Call occupies two instruction cycles
// [RL8] Invert writes complement to accumulator or register
// [RL9] Zero register clears it, sets zero flag
// [RL10] Decrement writes f minus one to destination
// [RL11] Zero accumulator clears it, sets zero flag
// [RL12] Zero flag follows result; skip, call untouched
module core_instruction_semantics #(
  parameter int STACK_DEPTH = 8,
  parameter int PRESCALE_W = 8
) (
  input wire logic clock, // Core clock, 250 MHz
  input wire logic rst, // Async reset, active high
  input wire logic instrValid, // Instruction presented
  output logic instrReady, // Unit takes an instruction this cycle
  input wire core_exec_pkg::opcode_t opcode, // Operation
  input wire logic [6:0] fileAddr, // Register file address
  input wire logic [2:0] bitSel, // Bit under test
  input wire logic destToFile, // 1: result to register, 0: to accumulator
  input wire logic [10:0] callTarget, // Call immediate
  input wire logic [4:0] address, // Avalon byte address
  input wire logic read, // Avalon read
  input wire logic write, // Avalon write
  input wire logic [31:0] writedata, // Avalon write data
  output logic [31:0] readdata, // Avalon read data
  output logic waitrequest, // Avalon wait
  output logic [12:0] programCounter, // Address of next instruction
  output logic [7:0] accumulator, // Working register
  output logic watchdogTimeout // One-cycle pulse on watchdog overflow
);

  localparam int WDT_W = 8;

  core_exec_pkg::exec_state_t state;
  logic [7:0] regFile [128];
  logic fire;
  logic execute;
  logic skipPending;
  logic [7:0] operand;
  logic [7:0] invResult;
  logic [7:0] decResult;
  logic bitIsSet;
  logic [4:0] upperPcLatch;
  logic [6:0] fileSel;
  logic zeroFlag;
  logic sleepEntryFlag;
  logic watchdogExpiryFlag;
  logic [PRESCALE_W-1:0] prescaler;
  logic [WDT_W-1:0] watchdogCount;
  logic prescaleWrap;
  logic watchdogWrap;
  logic kick;
  logic callNow;
  logic [12:0] stackTop;
  logic stackPop;
  logic ack;
  logic accept;
  logic [31:0] next_readdata;

  assign instrReady = (state == core_exec_pkg::EXEC_CYCLE); // [RL7]
  assign fire = instrValid && instrReady;
  // A discarded instruction is consumed and only advances the program counter
  assign execute = fire && !skipPending; // [RL1]
  assign operand = regFile[fileAddr];
  assign invResult = ~operand;
  assign decResult = operand - 8'h01;
  assign bitIsSet = operand[bitSel];
  assign kick = execute && (opcode == core_exec_pkg::OP_WATCHDOG_KICK);
  assign callNow = execute && (opcode == core_exec_pkg::OP_CALL);

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state <= core_exec_pkg::EXEC_CYCLE;
    end
    else
    begin
      case (state)
        core_exec_pkg::EXEC_CYCLE: if (callNow) state <= core_exec_pkg::CALL_SECOND_CYCLE; // [RL7]
        core_exec_pkg::CALL_SECOND_CYCLE: state <= core_exec_pkg::EXEC_CYCLE;
        default: state <= core_exec_pkg::EXEC_CYCLE;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      skipPending <= 1'b0;
    end
    else if (fire)
    begin
      skipPending <= execute && (opcode == core_exec_pkg::OP_BIT_TEST_SKIP_IF_ONE) && bitIsSet; // [RL1]
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      programCounter <= `PC_RST;
    end
    else if (callNow)
    begin
      programCounter <= {upperPcLatch[`PAGE_HI_BIT:`PAGE_LO_BIT], callTarget}; // [RL5] [RL6]
    end
    else if (fire)
    begin
      programCounter <= programCounter + 13'h0001;
    end
  end

  // Return address is the call's own address plus one
  return_stack #(
    .WIDTH(13),
    .DEPTH(STACK_DEPTH)
  ) u_stack (
    .clock(clock),
    .rst(rst),
    .push(callNow), // [RL4]
    .pushData(programCounter + 13'h0001), // [RL4]
    .pop(stackPop),
    .stackTop(stackTop)
  );

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      accumulator <= `ACCUM_RST;
    end
    else if (execute)
    begin
      case (opcode)
        core_exec_pkg::OP_ZERO_ACCUMULATOR: accumulator <= 8'h00; // [RL11]
        core_exec_pkg::OP_INVERT_REGISTER: if (!destToFile) accumulator <= invResult; // [RL8]
        core_exec_pkg::OP_DECREMENT_REGISTER: if (!destToFile) accumulator <= decResult; // [RL10]
        default: accumulator <= accumulator;
      endcase
    end
  end

  // Data array without reset; bus writes are held off while an instruction is presented
  always_ff @(posedge clock)
  begin
    if (execute && (opcode == core_exec_pkg::OP_ZERO_REGISTER))
      regFile[fileAddr] <= 8'h00; // [RL9]
    else if (execute && destToFile && (opcode == core_exec_pkg::OP_INVERT_REGISTER))
      regFile[fileAddr] <= invResult; // [RL8]
    else if (execute && destToFile && (opcode == core_exec_pkg::OP_DECREMENT_REGISTER))
      regFile[fileAddr] <= decResult; // [RL10]
    else if (accept && write && (address == `FILE_DATA_OFS))
      regFile[fileSel] <= writedata[7:0];
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      zeroFlag <= `ZERO_FLAG_RST;
    end
    else if (execute)
    begin
      case (opcode)
        core_exec_pkg::OP_ZERO_ACCUMULATOR: zeroFlag <= 1'b1; // [RL11]
        core_exec_pkg::OP_ZERO_REGISTER: zeroFlag <= 1'b1; // [RL9]
        core_exec_pkg::OP_INVERT_REGISTER: zeroFlag <= (invResult == 8'h00); // [RL12]
        core_exec_pkg::OP_DECREMENT_REGISTER: zeroFlag <= (decResult == 8'h00); // [RL12]
        default: zeroFlag <= zeroFlag; // [RL12]
      endcase
    end
  end

  assign prescaleWrap = &prescaler;
  assign watchdogWrap = prescaleWrap && (&watchdogCount);

  // Kick outranks a same-cycle overflow, so the counter never times out on a kick
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      prescaler <= '0;
      watchdogCount <= `WATCHDOG_CLEAR;
    end
    else if (kick)
    begin
      prescaler <= '0; // [RL2]
      watchdogCount <= `WATCHDOG_CLEAR; // [RL2]
    end
    else
    begin
      prescaler <= prescaler + PRESCALE_W'(1);
      if (prescaleWrap) watchdogCount <= watchdogCount + WDT_W'(1);
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      watchdogExpiryFlag <= `EXPIRY_FLAG_RST;
      sleepEntryFlag <= `SLEEP_FLAG_RST;
      watchdogTimeout <= 1'b0;
    end
    else
    begin
      watchdogTimeout <= watchdogWrap && !kick;
      if (kick)
      begin
        watchdogExpiryFlag <= 1'b1; // [RL3]
        sleepEntryFlag <= 1'b1; // [RL3]
      end
      else if (watchdogWrap) watchdogExpiryFlag <= 1'b0;
    end
  end

  // Bus is served only while no instruction is presented, so the two never race
  assign accept = (read || write) && ack && !instrValid;
  assign waitrequest = (read || write) && !accept;
  assign stackPop = accept && write && (address == `STACK_TOP_OFS) && !callNow;

  always_comb
  begin
    next_readdata = `READ_ZERO;
    case (address)
      `UPPER_LATCH_OFS: next_readdata[4:0] = upperPcLatch;
      `STATUS_OFS:
      begin
        next_readdata[`ZERO_FLAG_BIT] = zeroFlag;
        next_readdata[`SLEEP_FLAG_BIT] = sleepEntryFlag;
        next_readdata[`EXPIRY_FLAG_BIT] = watchdogExpiryFlag;
      end
      `ACCUM_OFS: next_readdata[7:0] = accumulator;
      `PC_OFS: next_readdata[12:0] = programCounter;
      `STACK_TOP_OFS: next_readdata[12:0] = stackTop;
      `WATCHDOG_OFS: next_readdata[7:0] = watchdogCount;
      `FILE_SEL_OFS: next_readdata[6:0] = fileSel;
      `FILE_DATA_OFS: next_readdata[7:0] = regFile[fileSel];
      default: next_readdata = `READ_ZERO;
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ack <= 1'b0;
      readdata <= `READ_ZERO;
    end
    else
    begin
      ack <= (read || write) && !accept;
      if (read && !accept) readdata <= next_readdata;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      upperPcLatch <= `UPPER_LATCH_RST;
      fileSel <= `FILE_SEL_RST;
    end
    else if (accept && write)
    begin
      if (address == `UPPER_LATCH_OFS) upperPcLatch <= writedata[4:0];
      if (address == `FILE_SEL_OFS) fileSel <= writedata[6:0];
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  sequence skipArmed;
    execute && (opcode == core_exec_pkg::OP_BIT_TEST_SKIP_IF_ONE) && bitIsSet;
  endsequence
  sequence discardedIssue;
    fire ##0 1'b1;
  endsequence
  sequence callIssued;
    callNow;
  endsequence

  skip_arm_a: assert property (skipArmed |=> skipPending) // [RL1]
    else $error("taken skip did not arm the discard");
  // A discarded call must not open a bubble either
  skip_discard_a: assert property (skipPending ##0 discardedIssue
      |=> $stable(accumulator) && $stable(zeroFlag) && !skipPending && instrReady) // [RL1]
    else $error("instruction after a taken skip was not discarded");
  wdt_clear_a: assert property (kick |=> (watchdogCount == 8'h00) && (prescaler == '0)) // [RL2]
    else $error("watchdog kick did not clear counter and prescaler");
  wdt_flags_a: assert property (kick |=> watchdogExpiryFlag && sleepEntryFlag && !watchdogTimeout) // [RL3]
    else $error("watchdog kick did not set both flags");
  call_push_a: assert property (callIssued |=> stackTop == $past(programCounter) + 13'h0001) // [RL4]
    else $error("call did not push the return address");
  call_low_pc_a: assert property (callIssued |=> programCounter[10:0] == $past(callTarget)) // [RL5]
    else $error("call target not loaded into low pc bits");
  call_page_a: assert property (callIssued |=> programCounter[12:11] == $past(upperPcLatch[4:3])) // [RL6]
    else $error("call page bits not taken from upper latch");
  call_cycles_a: assert property (callIssued |=> !instrReady ##1 instrReady) // [RL7]
    else $error("call did not take exactly two cycles");
  invert_acc_a: assert property (execute && (opcode == core_exec_pkg::OP_INVERT_REGISTER) && !destToFile
      |=> accumulator == ~$past(operand)) // [RL8]
    else $error("invert result missing from accumulator");
  zero_reg_a: assert property (execute && (opcode == core_exec_pkg::OP_ZERO_REGISTER)
      |=> zeroFlag && (regFile[$past(fileAddr)] == 8'h00)) // [RL9]
    else $error("zero register did not clear register and set flag");
  dec_dest_a: assert property (execute && (opcode == core_exec_pkg::OP_DECREMENT_REGISTER)
      |=> ($past(destToFile) ? regFile[$past(fileAddr)] : accumulator) == $past(operand) - 8'h01) // [RL10]
    else $error("decrement result wrong at destination");
  zero_acc_a: assert property (execute && (opcode == core_exec_pkg::OP_ZERO_ACCUMULATOR)
      |=> zeroFlag && (accumulator == 8'h00)) // [RL11]
    else $error("zero accumulator did not clear it and set flag");
  zero_track_a: assert property (execute && ((opcode == core_exec_pkg::OP_CALL)
      || (opcode == core_exec_pkg::OP_BIT_TEST_SKIP_IF_ONE)) |=> $stable(zeroFlag)
      && $stable(sleepEntryFlag)) // [RL12]
    else $error("skip or call disturbed status flags");

endmodule

// >>> rtl/return_stack.sv
// Circular hardware return stack, push from the core, pop from software.
// Assumes push and pop are not requested in the same cycle; push wins if they are.
`timescale 1ns/1ps

module return_stack #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 8
) (
  input wire logic clock, // Core clock
  input wire logic rst, // Async reset, active high
  input wire logic push, // Write pushData on top
  input wire logic [WIDTH-1:0] pushData, // Return address
  input wire logic pop, // Drop the top entry
  output logic [WIDTH-1:0] stackTop // Current top entry
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] entries [DEPTH];
  logic [PTR_W-1:0] nextFree;
  logic [PTR_W-1:0] topIndex;

  // Wraps silently like the real stack: overflow overwrites the oldest entry
  assign topIndex = nextFree - PTR_W'(1);
  assign stackTop = entries[topIndex];

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      nextFree <= '0;
    end
    else if (push)
    begin
      nextFree <= nextFree + PTR_W'(1);
    end
    else if (pop)
    begin
      nextFree <= topIndex;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        entries[i] <= '0;
      end
    end
    else if (push)
    begin
      entries[nextFree] <= pushData;
    end
  end

endmodule

// >>> verification/core_instruction_semantics_tb.sv
// Self-checking bench for the instruction execution unit.
// Assumes rtl/ on the include path; the bench drives instruction and register bus ports itself.
`timescale 1ns/1ps
`include "core_exec_defines.svh"

module core_instruction_semantics_tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic instrValid = 1'b0;
  core_exec_pkg::opcode_t opcode = core_exec_pkg::OP_NOP;
  logic [6:0] fileAddr = 7'h00;
  logic [2:0] bitSel = 3'h0;
  logic destToFile = 1'b0;
  logic [10:0] callTarget = 11'h000;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic instrReady;
  logic [31:0] readdata;
  logic waitrequest;
  logic [12:0] programCounter;
  logic [7:0] accumulator;
  logic watchdogTimeout;
  logic waitSeen;
  logic readySeen;
  logic [31:0] dataSeen;
  logic [31:0] rd;
  logic [12:0] pc0;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;

  // Short prescaler keeps the watchdog wrap near a thousand cycles
  core_instruction_semantics #(.STACK_DEPTH(8), .PRESCALE_W(2)) dut (.clock(clock), .rst(rst),
    .instrValid(instrValid), .instrReady(instrReady), .opcode(opcode), .fileAddr(fileAddr),
    .bitSel(bitSel), .destToFile(destToFile), .callTarget(callTarget), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .programCounter(programCounter), .accumulator(accumulator),
    .watchdogTimeout(watchdogTimeout));

  always #2 clock = ~clock;

  // Settled mid-cycle copies avoid racing the edge that updates them
  always @(negedge clock)
  begin
    waitSeen = waitrequest;
    readySeen = instrReady;
    dataSeen = readdata;
  end

  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 8000)
    begin
      mismatches++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus_read(input logic [4:0] a, output logic [31:0] d);
    read <= 1'b1;
    address <= a;
    do @(posedge clock); while (waitSeen !== 1'b0);
    d = dataSeen;
    read <= 1'b0;
    @(posedge clock);
  endtask

  task automatic bus_write(input logic [4:0] a, input logic [31:0] d);
    write <= 1'b1;
    address <= a;
    writedata <= d;
    do @(posedge clock); while (waitSeen !== 1'b0);
    write <= 1'b0;
    @(posedge clock);
  endtask

  task automatic exec(input core_exec_pkg::opcode_t op, input logic [6:0] f, input logic [2:0] b,
    input logic d, input logic [10:0] k);
    instrValid <= 1'b1;
    opcode <= op;
    fileAddr <= f;
    bitSel <= b;
    destToFile <= d;
    callTarget <= k;
    do @(posedge clock); while (readySeen !== 1'b1);
    instrValid <= 1'b0;
    @(posedge clock);
  endtask

  task automatic set_file(input logic [6:0] f, input logic [7:0] v);
    bus_write(`FILE_SEL_OFS, {25'h0, f});
    bus_write(`FILE_DATA_OFS, {24'h00_0000, v});
  endtask

  task automatic t_reset();
    bus_read(`STATUS_OFS, rd);
    check("status after reset", rd, 32'h0000_0018);
    check("pc after reset", {19'h0, programCounter}, 32'h0000_0000);
    $display("reset test done");
  endtask

  task automatic t_invert();
    set_file(7'h05, 8'hA5);
    exec(core_exec_pkg::OP_INVERT_REGISTER, 7'h05, 3'h0, 1'b0, 11'h000);
    check("invert to acc", {24'h0, accumulator}, 32'h0000_005A);
    bus_read(`STATUS_OFS, rd);
    check("zero after invert", {31'h0, rd[`ZERO_FLAG_BIT]}, 32'h0000_0000);
    exec(core_exec_pkg::OP_INVERT_REGISTER, 7'h05, 3'h0, 1'b1, 11'h000);
    bus_read(`FILE_DATA_OFS, rd);
    check("invert to file", rd, 32'h0000_005A);
    set_file(7'h06, 8'hFF);
    exec(core_exec_pkg::OP_INVERT_REGISTER, 7'h06, 3'h0, 1'b0, 11'h000);
    bus_read(`STATUS_OFS, rd);
    check("zero after invert ff", {31'h0, rd[`ZERO_FLAG_BIT]}, 32'h0000_0001);
    $display("invert test done");
  endtask

  task automatic t_decrement();
    set_file(7'h07, 8'h01);
    exec(core_exec_pkg::OP_DECREMENT_REGISTER, 7'h07, 3'h0, 1'b1, 11'h000);
    bus_read(`FILE_DATA_OFS, rd);
    check("decrement to file", rd, 32'h0000_0000);
    exec(core_exec_pkg::OP_DECREMENT_REGISTER, 7'h07, 3'h0, 1'b0, 11'h000);
    check("decrement to acc", {24'h0, accumulator}, 32'h0000_00FF);
    bus_read(`STATUS_OFS, rd);
    check("zero after wrap", {31'h0, rd[`ZERO_FLAG_BIT]}, 32'h0000_0000);
    bus_read(`FILE_DATA_OFS, rd);
    check("file kept", rd, 32'h0000_0000);
    $display("decrement test done");
  endtask

  task automatic t_zero();
    set_file(7'h08, 8'h3C);
    exec(core_exec_pkg::OP_ZERO_REGISTER, 7'h08, 3'h0, 1'b0, 11'h000);
    bus_read(`FILE_DATA_OFS, rd);
    check("zero register", rd, 32'h0000_0000);
    bus_read(`STATUS_OFS, rd);
    check("zero flag set", {31'h0, rd[`ZERO_FLAG_BIT]}, 32'h0000_0001);
    exec(core_exec_pkg::OP_DECREMENT_REGISTER, 7'h08, 3'h0, 1'b0, 11'h000);
    exec(core_exec_pkg::OP_ZERO_ACCUMULATOR, 7'h00, 3'h0, 1'b0, 11'h000);
    check("zero acc", {24'h0, accumulator}, 32'h0000_0000);
    bus_read(`STATUS_OFS, rd);
    check("zero flag acc", {31'h0, rd[`ZERO_FLAG_BIT]}, 32'h0000_0001);
    $display("zero test done");
  endtask

  task automatic t_skip();
    set_file(7'h10, 8'h04);
    pc0 = programCounter;
    exec(core_exec_pkg::OP_BIT_TEST_SKIP_IF_ONE, 7'h10, 3'h2, 1'b0, 11'h000);
    exec(core_exec_pkg::OP_INVERT_REGISTER, 7'h10, 3'h0, 1'b0, 11'h000);
    check("skipped acc", {24'h0, accumulator}, 32'h0000_0000);
    check("skipped pc", {19'h0, programCounter}, {19'h0, pc0 + 13'h0002});
    bus_read(`STATUS_OFS, rd);
    check("skip keeps zero", {31'h0, rd[`ZERO_FLAG_BIT]}, 32'h0000_0001);
    exec(core_exec_pkg::OP_BIT_TEST_SKIP_IF_ONE, 7'h10, 3'h0, 1'b0, 11'h000);
    exec(core_exec_pkg::OP_INVERT_REGISTER, 7'h10, 3'h0, 1'b0, 11'h000);
    check("not skipped acc", {24'h0, accumulator}, 32'h0000_00FB);
    $display("skip test done");
  endtask

  task automatic t_call();
    bus_write(`UPPER_LATCH_OFS, 32'h0000_0018);
    pc0 = programCounter;
    exec(core_exec_pkg::OP_CALL, 7'h00, 3'h0, 1'b0, 11'h5A5);
    check("call bubble", {31'h0, readySeen}, 32'h0000_0000);
    check("call pc", {19'h0, programCounter}, 32'h0000_1DA5);
    bus_read(`STACK_TOP_OFS, rd);
    check("return address", rd, {19'h0, pc0 + 13'h0001});
    check("ready after call", {31'h0, readySeen}, 32'h0000_0001);
    bus_read(`STATUS_OFS, rd);
    check("call keeps zero", {31'h0, rd[`ZERO_FLAG_BIT]}, 32'h0000_0000);
    $display("call test done");
  endtask

  task automatic t_watchdog();
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 3000 && !seen; i++)
      @(negedge clock) seen = (watchdogTimeout === 1'b1);
    @(posedge clock);
    check("watchdog wrapped", {31'h0, seen}, 32'h0000_0001);
    bus_read(`STATUS_OFS, rd);
    check("expiry cleared", {31'h0, rd[`EXPIRY_FLAG_BIT]}, 32'h0000_0000);
    exec(core_exec_pkg::OP_WATCHDOG_KICK, 7'h00, 3'h0, 1'b0, 11'h000);
    bus_read(`WATCHDOG_OFS, rd);
    check("watchdog cleared", rd, 32'h0000_0000);
    bus_read(`STATUS_OFS, rd);
    check("kick flags", {30'h0, rd[`EXPIRY_FLAG_BIT], rd[`SLEEP_FLAG_BIT]}, 32'h0000_0003);
    $display("watchdog test done");
  endtask

  initial
  begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_invert();
    t_decrement();
    t_zero();
    t_skip();
    t_call();
    t_watchdog();
    test_done();
  end
endmodule
